/* design/dqd_cfg.svh */
`ifndef DQD_CFG_SVH
`define DQD_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DQD_OFF_VERSION 12'h000
`define DQD_OFF_SCHED_CTRL 12'h004
`define DQD_OFF_DIVERT 12'h008
`define DQD_OFF_DIV_STATUS 12'h00c
`define DQD_OFF_STARVE0 12'h010
`define DQD_OFF_SCHED_WORD0 12'h100

// ****************************************
// Field positions and widths
// ****************************************
`define DQD_DIV_TAIL_BIT 31
`define DQD_DIV_DST_LSB 16
`define DQD_DIV_SRC_LSB 0
`define DQD_QNUM_W 14
`define DQD_SLOT_DIR_BIT 7
`define DQD_SLOT_CHAN_LSB 0
`define DQD_SLOT_W 8
`define DQD_CTRL_EN_BIT 0
`define DQD_CTRL_LAST_LSB 4
`define DQD_SCHED_WORDS 4
`define DQD_STARVE_REGS 4

// ****************************************
// Masks and reset values
// ****************************************
`define DQD_SCHED_WORD_MASK 32'h8f8f8f8f
`define DQD_DIVERT_MASK 32'hbfff3fff
`define DQD_SCHED_CTRL_MASK 32'h000000f1
`define DQD_RST_WORD 32'h00000000
// Arbitrary revision value, not tied to any real part
`define DQD_VERSION_CODE 32'h00010000
`define DQD_CNT_MAX 8'hff

`endif

/* design/dqd_pkg.sv */
// ****************************************
// Shared types
// ****************************************
package dqd_pkg;

	// Diversion engine states
	typedef enum logic [0:0] {
		DIV_IDLE,
		DIV_BUSY
	} dqd_div_st_t;

	// Register slave and diversion state
	typedef struct packed {
		logic aw_full;
		logic [11:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [3:0][31:0] sched_word;
		logic sched_en;
		logic [3:0] sched_last;
		logic div_tail;
		logic [13:0] div_dst;
		logic [13:0] div_src;
		dqd_div_st_t div_st;
	} dqd_top_st_t;

	// Scheduler walker state
	typedef struct packed {
		logic [3:0] idx;
		logic cvalid;
		logic cdir;
		logic [3:0] cqueue;
		logic [3:0] cchan;
	} dqd_sched_st_t;

	// Starvation counters
	typedef struct packed {
		logic [15:0][7:0] cnt;
	} dqd_starve_st_t;

endpackage

/* design/dqd_sched.sv */
`timescale 1ns/10ps
`include "dqd_cfg.svh"

// Walks the scheduler table and hands out one credit per entry
module dqd_sched (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [127:0] table_flat,
	input wire logic sched_en,
	input wire logic [3:0] sched_last,
	input wire logic [63:0] rx_head_chan,
	input wire logic credit_ready,
	output logic credit_valid,
	output logic credit_dir,
	output logic [3:0] credit_queue,
	output logic [3:0] credit_chan
);

	// ****************************************
	// Slot decoding
	// ****************************************

	// Slot byte of entry i, four slots per word
	function automatic logic [7:0] slot_of(input logic [127:0] t, input logic [3:0] i);
		slot_of = t[i*`DQD_SLOT_W +: `DQD_SLOT_W];
	endfunction

	dqd_pkg::dqd_sched_st_t q, d; // Walker state
	logic [7:0] slot; // Entry being loaded
	logic [3:0] fifo_chan; // Head channel of that entry's receive FIFO

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		slot = slot_of(table_flat, q.idx);
		fifo_chan = rx_head_chan[slot[3:0]*4 +: 4];
		// Load a new credit when none is held or the held one is taken
		if (!q.cvalid || credit_ready) begin
			if (sched_en) begin
				d.cvalid = 1'b1;
				d.cdir = slot[`DQD_SLOT_DIR_BIT];
				d.cqueue = slot[`DQD_SLOT_CHAN_LSB +: 4];
				d.cchan = slot[`DQD_SLOT_CHAN_LSB +: 4];
				if (slot[`DQD_SLOT_DIR_BIT]) begin
					d.cqueue = slot[`DQD_SLOT_CHAN_LSB +: 4];
					d.cchan = fifo_chan;
				end
				// Wrap after the last programmed entry
				d.idx = (q.idx >= sched_last) ? 4'h0 : q.idx + 4'h1;
			end else begin
				// Disabled: stop handing out credits, restart at entry zero
				d.cvalid = 1'b0;
				d.idx = 4'h0;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign credit_valid = q.cvalid;
	assign credit_dir = q.cdir;
	assign credit_queue = q.cqueue;
	assign credit_chan = q.cchan;

endmodule // dqd_sched

/* design/dqd_starve.sv */
`timescale 1ns/10ps
`include "dqd_cfg.svh"

// Sixteen 8-bit empty-read counters, cleared when their register is read
module dqd_starve (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] free_pop,
	input wire logic [15:0] free_empty,
	input wire logic [3:0] rd_clr,
	output logic [127:0] cnt_flat
);

	dqd_pkg::dqd_starve_st_t q, d; // Counter state
	logic [15:0][7:0] cnt_nx; // Per-counter next value

	// ****************************************
	// Per-counter update
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_cnt
			logic hit; // Pop of an empty queue
			logic [7:0] base; // Value after any clear
			assign hit = free_pop[g] && free_empty[g];
			assign base = rd_clr[g/4] ? 8'h00 : q.cnt[g];
			// Saturate so a busy queue never wraps to a small count; a hit in the clearing cycle counts as one
			assign cnt_nx[g] = (hit && base != `DQD_CNT_MAX) ? base + 8'h01 : base;
		end
	endgenerate

	// Collect next values
	always_comb begin
		d = q;
		d.cnt = cnt_nx;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign cnt_flat = q.cnt;

endmodule // dqd_starve

/* design/dqd_top.sv */
`timescale 1ns/10ps
`include "dqd_cfg.svh"

// Function
// - Slot bit seven: zero transmit, one receive
// - Four-bit channel; transmit credit names it exactly
// - Receive slot credits its channel's receive FIFO
// - Shared FIFO credit carries head element channel
// - Read-only 32-bit queue manager version register
// - Divert source bits 13-0 onto destination 29-16
// - Bit 31: zero merges head, one tail
// - Starvation fields clear when read
// - 8-bit counters count reads of empty queues
module dqd_top (
	input wire logic clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Scheduling credit to the DMA
	output logic credit_valid,
	input wire logic credit_ready,
	output logic credit_dir,
	output logic [3:0] credit_queue,
	output logic [3:0] credit_chan,
	// Head element channel of each receive FIFO, four bits each
	input wire logic [63:0] rx_head_chan,
	// Free queue pops and emptiness
	input wire logic [15:0] free_pop,
	input wire logic [15:0] free_empty,
	// Diversion request to the queue linker
	output logic div_req,
	output logic [13:0] div_src,
	output logic [13:0] div_dst,
	output logic div_tail,
	input wire logic div_done
);

	// ****************************************
	// Constants and helpers
	// ****************************************

	localparam logic [1:0] RESP_OKAY = 2'b00; // Normal answer
	localparam logic [1:0] RESP_SLVERR = 2'b10; // Refused access

	// Byte enables expanded to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	// Index of a scheduler word, or 4'hf when the address is elsewhere
	function automatic logic [3:0] sched_idx(input logic [11:0] a);
		if (a >= `DQD_OFF_SCHED_WORD0 && a < `DQD_OFF_SCHED_WORD0 + 12'h4 * `DQD_SCHED_WORDS) begin
			// Subtract before shifting so each word gets its own index
			sched_idx = {2'b00, 2'((a - `DQD_OFF_SCHED_WORD0) >> 2)};
		end else begin
			sched_idx = 4'hf;
		end
	endfunction

	// Index of a starvation register, or 4'hf when the address is elsewhere
	function automatic logic [3:0] starve_idx(input logic [11:0] a);
		if (a >= `DQD_OFF_STARVE0 && a < `DQD_OFF_STARVE0 + 12'h4 * `DQD_STARVE_REGS) begin
			starve_idx = {2'b00, 2'((a - `DQD_OFF_STARVE0) >> 2)};
		end else begin
			starve_idx = 4'hf;
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************

	dqd_pkg::dqd_top_st_t q, d; // All slave and control state
	logic do_wr; // Both write halves held, response slot free
	logic do_rd; // Read address taken this cycle
	logic wr_full; // All four byte lanes enabled
	logic [11:0] wa; // Word-aligned write address
	logic [11:0] ra; // Word-aligned read address
	logic [3:0] wr_sidx; // Scheduler word hit by the write
	logic [3:0] rd_sidx; // Scheduler word hit by the read
	logic [3:0] rd_cidx; // Starvation register hit by the read
	logic [3:0] rd_clr; // Clear strobes to the counters
	logic [31:0] wmask; // Lanes written
	logic [31:0] divert_rd; // Divert register as read back
	logic [127:0] cnt_flat; // All starvation counters
	logic [127:0] table_flat; // Scheduler table to the walker

	// ****************************************
	// Handshake decode
	// ****************************************
	always_comb begin
		wa = {q.aw_addr[11:2], 2'b00};
		ra = {s_axi_araddr[11:2], 2'b00};
		do_wr = q.aw_full && q.w_full && !q.bvalid;
		do_rd = s_axi_arvalid && !q.rvalid;
		wr_full = (q.w_strb == 4'hf);
		wmask = strb_mask(q.w_strb);
		wr_sidx = sched_idx(wa);
		rd_sidx = sched_idx(ra);
		rd_cidx = starve_idx(ra);
		divert_rd = {q.div_tail, 1'b0, q.div_dst, 2'b00, q.div_src} & `DQD_DIVERT_MASK;
		rd_clr = 4'h0;
		if (do_rd && rd_cidx != 4'hf) begin
			rd_clr[rd_cidx[1:0]] = 1'b1;
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		// Capture write address and data independently, in either order
		if (!q.aw_full && s_axi_awvalid) begin
			d.aw_full = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (!q.w_full && s_axi_wvalid) begin
			d.w_full = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		// Response retires when the master takes it
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end

		// Register write
		if (do_wr) begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			if (wr_sidx != 4'hf) begin
				d.sched_word[wr_sidx[1:0]] = (q.sched_word[wr_sidx[1:0]] & ~wmask)
					| (q.w_data & wmask & `DQD_SCHED_WORD_MASK);
			end else begin
				case (wa)
					`DQD_OFF_SCHED_CTRL: begin
						// Byte writes allowed here; lane 0 holds both fields
						if (q.w_strb[0]) begin
							d.sched_en = q.w_data[`DQD_CTRL_EN_BIT];
							d.sched_last = q.w_data[`DQD_CTRL_LAST_LSB +: 4];
						end
					end
					`DQD_OFF_DIVERT: begin
						if (!wr_full || q.div_st != dqd_pkg::DIV_IDLE) begin
							d.bresp = RESP_SLVERR;
						end else begin
							d.div_src = q.w_data[`DQD_DIV_SRC_LSB +: `DQD_QNUM_W];
							d.div_dst = q.w_data[`DQD_DIV_DST_LSB +: `DQD_QNUM_W];
							d.div_tail = q.w_data[`DQD_DIV_TAIL_BIT];
							d.div_st = dqd_pkg::DIV_BUSY;
						end
					end
					`DQD_OFF_VERSION, `DQD_OFF_DIV_STATUS: begin
						// Read-only registers ignore writes
						d.bresp = RESP_OKAY;
					end
					default: begin
						// Starvation registers are read-only; anything else is unmapped
						d.bresp = (starve_idx(wa) != 4'hf) ? RESP_OKAY : RESP_SLVERR;
					end
				endcase
			end
		end

		// Register read, answered one cycle after the address is taken
		if (do_rd) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = `DQD_RST_WORD;
			if (rd_sidx != 4'hf) begin
				d.rdata = q.sched_word[rd_sidx[1:0]];
			end else if (rd_cidx != 4'hf) begin
				d.rdata = cnt_flat[rd_cidx[1:0]*32 +: 32];
			end else begin
				case (ra)
					`DQD_OFF_VERSION: d.rdata = `DQD_VERSION_CODE;
					`DQD_OFF_SCHED_CTRL: d.rdata = {24'h0, q.sched_last, 3'b000, q.sched_en};
					`DQD_OFF_DIVERT: d.rdata = divert_rd;
					`DQD_OFF_DIV_STATUS: d.rdata = {31'h0, q.div_st == dqd_pkg::DIV_BUSY};
					default: d.rresp = RESP_SLVERR;
				endcase
			end
		end

		// Diversion engine
		case (q.div_st)
			dqd_pkg::DIV_IDLE: begin
				// Waiting for a full-word write to the divert register
			end
			dqd_pkg::DIV_BUSY: begin
				if (div_done) begin
					d.div_st = dqd_pkg::DIV_IDLE;
				end
			end
			default: begin
				d.div_st = dqd_pkg::DIV_IDLE;
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Bus outputs
	// ****************************************

	// Ready while the holding slot is empty; the master may offer either half first
	assign s_axi_awready = !q.aw_full;
	assign s_axi_wready = !q.w_full;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	// One read at a time: no new address while an answer stands
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	// Diversion request held until the linker reports the move complete
	assign div_req = (q.div_st == dqd_pkg::DIV_BUSY);
	assign div_src = q.div_src;
	assign div_dst = q.div_dst;
	assign div_tail = q.div_tail;

	assign table_flat = q.sched_word;

	// ****************************************
	// Submodules
	// ****************************************

	// Credit walker over the table
	dqd_sched u_sched (
		.clk(clk),
		.rst_n(rst_n),
		.table_flat(table_flat),
		.sched_en(q.sched_en),
		.sched_last(q.sched_last),
		.rx_head_chan(rx_head_chan),
		.credit_ready(credit_ready),
		.credit_valid(credit_valid),
		.credit_dir(credit_dir),
		.credit_queue(credit_queue),
		.credit_chan(credit_chan)
	);

	// Empty-read statistics
	dqd_starve u_starve (
		.clk(clk),
		.rst_n(rst_n),
		.free_pop(free_pop),
		.free_empty(free_empty),
		.rd_clr(rd_clr),
		.cnt_flat(cnt_flat)
	);

endmodule // dqd_top

/* verif/dqd_chk.sv */
`timescale 1ns/10ps

// ****************************************
// Port checker for the queue divert block
// ****************************************
module dqd_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic credit_valid,
	input wire logic credit_ready,
	input wire logic credit_dir,
	input wire logic [3:0] credit_queue,
	input wire logic [3:0] credit_chan,
	input wire logic [63:0] rx_head_chan,
	input wire logic div_req,
	input wire logic div_done,
	input wire logic [13:0] div_src,
	input wire logic [13:0] div_dst,
	input wire logic div_tail
);
	// One domain, so clock and reset are given once
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_credit_hold: assert property (credit_valid && !credit_ready |=>
		credit_valid && $stable({credit_dir, credit_queue, credit_chan})) else $error("credit changed before taken");
	a_tx_exact: assert property (credit_valid && !credit_dir |-> credit_chan == credit_queue)
		else $error("transmit credit channel differs");
	// Head channel is sampled on the load edge
	a_rx_head: assert property (credit_valid && credit_dir && ($rose(credit_valid) ||
		$past(credit_valid && credit_ready)) |-> credit_chan == 4'($past(rx_head_chan) >> (4 * credit_queue)))
		else $error("receive credit not head channel");
	a_div_hold: assert property (div_req && !div_done |=>
		div_req && $stable({div_tail, div_dst, div_src})) else $error("divert request moved");
	a_div_end: assert property (div_req && div_done |=> !div_req) else $error("divert not ended");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data changed");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response changed");
endmodule // dqd_chk

/* verif/dqd_dma_model.sv */
`timescale 1ns/10ps

// ****************************************
// DMA channels and queue linker model
// ****************************************
module dqd_dma_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic div_req,
	input wire logic [5:0] div_delay,
	output logic credit_ready,
	output logic div_done
);
	logic [6:0] wait_q; // Cycles spent on the current move

	// Random stalls so credits are both taken promptly and held
	always_ff @(posedge clk) begin
		credit_ready <= rst_n && ($urandom_range(0, 3) != 0);
	end

	// One done pulse per move, after the chosen delay
	always_ff @(posedge clk) begin
		if (!rst_n || !div_req) begin
			wait_q <= 7'h00;
			div_done <= 1'b0;
		end else begin
			div_done <= (wait_q == {1'b0, div_delay});
			if (wait_q <= {1'b0, div_delay}) begin
				wait_q <= wait_q + 7'h01;
			end
		end
	end
endmodule // dqd_dma_model

/* verif/dqd_top_bench.sv */
`timescale 1ns/10ps
`include "dqd_cfg.svh"

// ****************************************
// Self-checking bench
// ****************************************
module dqd_top_bench;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, e, p, m;
	logic [3:0] s_axi_wstrb = 4'h0, credit_queue, credit_chan, ch;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic credit_valid, credit_ready, credit_dir, div_req, div_tail, div_done;
	logic [13:0] div_src, div_dst;
	logic [63:0] rx_head_chan = 64'h0;
	logic [15:0] free_pop = 16'h0, free_empty = 16'h0;
	logic [5:0] div_delay = 6'h28; // Long enough to write while busy
	int n_errors = 0, check_count = 0;
	int wv[4], cnt[16], i, n, k, t;

	always #10 clk = ~clk;

	dqd_top i_dqd_top (.*);
	dqd_dma_model i_dqd_dma_model (.clk(clk), .rst_n(rst_n), .div_req(div_req), .div_delay(div_delay),
		.credit_ready(credit_ready), .div_done(div_done));

	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] got);
		check_count++;
		if (got !== ex) begin
			$display("wrong value %s expected %h seen %h", nm, ex, got);
			n_errors++;
		end
	endtask

	// Write; bready comes late so the response must stand
	task automatic axw(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s, output logic [1:0] r);
		int j;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dv;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (j == 3) s_axi_bready <= 1'b1;
			if (s_axi_bvalid && s_axi_bready) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (j == 50) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	// Read; rready comes late so the data must stand
	task automatic axr(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] r);
		int j;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (j == 2) s_axi_rready <= 1'b1;
			if (s_axi_rvalid && s_axi_rready) break;
		end
		dv = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (j == 50) begin
			n_errors++;
			tally_and_finish();
		end
	endtask

	initial begin
		rd = $urandom(32'ha776);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		// ****************************************
		// Version, unmapped place
		// ****************************************
		axw(`DQD_OFF_VERSION, 32'hffffffff, 4'hf, rs);
		axr(`DQD_OFF_VERSION, rd, rs);
		chk("version", {2'h0, `DQD_VERSION_CODE}, {rs, rd});
		axr(12'h020, rd, rs);
		chk("unmapped read", {2'h2, 32'h0}, {rs, rd});
		axw(12'h020, 32'h1, 4'hf, rs);
		chk("unmapped write", 34'h2, rs);
		// ****************************************
		// Scheduler table and credits
		// ****************************************
		for (i = 0; i < 4; i++) begin
			wv[i] = $urandom;
			axw(12'(`DQD_OFF_SCHED_WORD0 + 4 * i), wv[i], 4'hf, rs);
			axr(12'(`DQD_OFF_SCHED_WORD0 + 4 * i), rd, rs);
			chk("sched word", wv[i] & `DQD_SCHED_WORD_MASK, rd);
		end
		rx_head_chan <= {$urandom, $urandom};
		// Last entry 11, so twenty credits cross the wrap
		// Watch from the enabling write on: credits start before its response retires
		i = 0;
		fork
			axw(`DQD_OFF_SCHED_CTRL, 32'h000000b1, 4'hf, rs);
			for (n = 0; n < 2000 && i < 20; n++) begin
				@(posedge clk);
				if (credit_valid && credit_ready) begin
					e = wv[(i % 12) / 4] >> (8 * (i % 4));
					ch = e[3:0];
					chk("credit", {e[7], ch, e[7] ? rx_head_chan[ch*4+:4] : ch}, {credit_dir, credit_queue, credit_chan});
					i++;
				end
			end
		join
		chk("credit count", 20, i);
		axr(`DQD_OFF_SCHED_CTRL, rd, rs);
		chk("sched ctrl", 34'hb1, {rs, rd});
		axw(`DQD_OFF_SCHED_CTRL, 32'h0, 4'hf, rs);
		// Disabled walker drops its credit once the held one is taken
		repeat (20) @(posedge clk);
		chk("credits stopped", 34'h0, credit_valid);
		// ****************************************
		// Diversion, head then tail
		// ****************************************
		for (t = 0; t < 2; t++) begin
			e = $urandom;
			e[31] = t[0];
			axw(`DQD_OFF_DIVERT, e, 4'hf, rs);
			chk("divert out", {2'h0, 1'b1, e[31], e[29:16], e[13:0]}, {rs, div_req, div_tail, div_dst, div_src});
			axr(`DQD_OFF_DIVERT, rd, rs);
			chk("divert read", e & `DQD_DIVERT_MASK, rd);
			axr(`DQD_OFF_DIV_STATUS, rd, rs);
			chk("divert busy", 32'h1, rd);
			axw(`DQD_OFF_DIVERT, ~e, 4'hf, rs);
			chk("divert busy write", 34'h2, rs);
			for (n = 0; n < 200 && div_req; n++) @(posedge clk);
			chk("divert done", 34'h0, div_req);
			axw(`DQD_OFF_DIVERT, e, 4'h3, rs);
			chk("partial write", 34'h2, rs);
			axr(`DQD_OFF_DIV_STATUS, rd, rs);
			chk("partial no start", {2'h0, 32'h0}, {rs, rd});
			// Move must outlast the busy read and the refused write above
			div_delay <= 6'($urandom_range(20, 40));
		end
		// ****************************************
		// Starvation counters, with saturation on queue 0
		// ****************************************
		for (n = 0; n <= 500; n++) begin
			@(posedge clk);
			p = n < 200 ? $urandom : (n < 500 ? 32'h1 : 32'h0);
			m = n < 200 ? $urandom : p;
			free_pop <= p[15:0];
			free_empty <= m[15:0];
			for (k = 0; k < 16; k++) cnt[k] += p[k] & m[k];
		end
		for (i = 0; i < 4; i++) begin
			for (k = 0; k < 4; k++) e[8*k+:8] = cnt[4*i+k] > 255 ? 8'hff : 8'(cnt[4*i+k]);
			axr(12'(`DQD_OFF_STARVE0 + 4 * i), rd, rs);
			chk("starve count", e, rd);
			axr(12'(`DQD_OFF_STARVE0 + 4 * i), rd, rs);
			chk("starve cleared", 32'h0, rd);
		end
		tally_and_finish();
	end
endmodule // dqd_top_bench

bind dqd_top dqd_chk i_dqd_chk (.*);
